/* File: hdl/dpc_pkg.sv */
package dpc_pkg;
  // ==========================================================
  // Frame field layout
  localparam int OPC_MSB    = 7;
  localparam int OPC_LSB    = 4;
  localparam int SEL_HI_BIT = 3;
  localparam int SEL_LO_BIT = 2;
  localparam int ZERO_BIT   = 1;
  localparam int POT_BIT    = 0;
  localparam int ADR_HI_BIT = 1;
  localparam int ADR_LO_BIT = 0;
  localparam int ADR_PAD_HI = 3;
  localparam int ADR_PAD_LO = 2;

  // Value is arbitrary, not a real part code
  localparam logic [3:0] DEV_TYPE_CODE = 4'h6;

  // ==========================================================
  // Opcodes
  localparam logic [3:0] OP_RD_WIPER  = 4'h9;
  localparam logic [3:0] OP_WR_WIPER  = 4'ha;
  localparam logic [3:0] OP_RD_STORE  = 4'hb;
  localparam logic [3:0] OP_WR_STORE  = 4'hc;
  localparam logic [3:0] OP_COPY_S2W  = 4'hd;
  localparam logic [3:0] OP_COPY_W2S  = 4'he;
  localparam logic [3:0] OP_GCOPY_S2W = 4'h1;
  localparam logic [3:0] OP_GCOPY_W2S = 4'h8;
  localparam logic [3:0] OP_STEP      = 4'h2;
  localparam logic [7:0] STATUS_INSTR = 8'h51;

  // ==========================================================
  // Widths, reset values and timing
  localparam int         NV_CNT_W     = 20;
  localparam logic [7:0] STORE_RST    = 8'h00;
  localparam logic [7:0] WIPER_MAX    = 8'hff;
  localparam logic [7:0] WIPER_MIN    = 8'h00;
  localparam logic [2:0] BIT_LAST     = 3'h7;
  localparam int         CLK_MHZ      = 100;
  localparam int         NV_WRITE_MS  = 10;
  localparam int         NV_WRITE_CYC = NV_WRITE_MS * CLK_MHZ * 1000;
  localparam int         WIPER_DLY_NS = 20;
  localparam logic [1:0] WIPER_DLY_CYC =
    2'((WIPER_DLY_NS * CLK_MHZ + 999) / 1000);

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_IDENT  = 3'b001,
    ST_INSTR  = 3'b010,
    ST_DATA   = 3'b011,
    ST_ARMED  = 3'b100,
    ST_STEP   = 3'b101,
    ST_IGNORE = 3'b110
  } dpc_state_type;
endpackage

/* File: hdl/dpc_decoder.sv */
`timescale 1ns/1ps
// Contract
// - Frame starts at chip select fall, sample rising
// - Identification byte type and address must match
// - Instruction byte: opcode, selects, zero, pot
// - Selects pick stored slot, pot bit picks pot
// - Opcode 1001 reads wiper on third byte
// - Opcode 1010 writes wiper from third byte
// - Opcode 1011 reads stored setting
// - Opcode 1100 writes stored setting, starts NV
// - Status read returns write busy bit
// - Transfers are two bytes, execute at frame end
// - Opcode 1101 copies stored setting to wiper
// - Stored to wiper copy lands after delay
// - Opcode 1110 copies wiper to stored slot
// - Wiper to stored copy is NV write
// - Global transfers act on both pots
// - Opcode 0001 copies stored to both wipers
// - Opcode 1000 copies both wipers to stored
// - Opcode 0010 enables stepping for frame
// - Any number of step pulses until frame end
// - Step with data high increments wiper
// - Step with data low decrements wiper
// - NV write bounded, busy flag throughout
module dpc_decoder #(
  parameter int NV_WRITE_CYC = dpc_pkg::NV_WRITE_CYC
) (
  // Clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_arst_n,
  // Serial link
  input  wire logic       i_sck,
  input  wire logic       i_cs_n,
  input  wire logic       i_si,
  output      logic       o_so,
  output      logic       o_so_oe,
  // Address straps
  input  wire logic       i_addr_pin_hi,
  input  wire logic       i_addr_pin_lo,
  // Wiper and status
  output      logic [7:0] o_wiper0,
  output      logic [7:0] o_wiper1,
  output      logic       o_write_busy_flag
);

  // ==========================================================
  // Instruction check
  function automatic logic instr_ok(input logic [7:0] b);
    logic [3:0] op;
    logic       sel0;
    op   = b[dpc_pkg::OPC_MSB:dpc_pkg::OPC_LSB];
    sel0 = ~b[dpc_pkg::SEL_HI_BIT] & ~b[dpc_pkg::SEL_LO_BIT];
    instr_ok = 1'b0;
    if (b == dpc_pkg::STATUS_INSTR) begin
      instr_ok = 1'b1;
    end else if (!b[dpc_pkg::ZERO_BIT]) begin
      case (op)
        dpc_pkg::OP_RD_WIPER,
        dpc_pkg::OP_WR_WIPER,
        dpc_pkg::OP_STEP:      instr_ok = sel0;
        dpc_pkg::OP_RD_STORE,
        dpc_pkg::OP_WR_STORE,
        dpc_pkg::OP_COPY_S2W,
        dpc_pkg::OP_COPY_W2S:  instr_ok = 1'b1;
        dpc_pkg::OP_GCOPY_S2W,
        dpc_pkg::OP_GCOPY_W2S: instr_ok = ~b[dpc_pkg::POT_BIT];
        default:               instr_ok = 1'b0;
      endcase
    end
  endfunction

  // ==========================================================
  // Storage and state
  // Local copy keeps the timer width readable below
  localparam int NV_CNT_W = dpc_pkg::NV_CNT_W;

  dpc_pkg::dpc_state_type state_ff;
  dpc_pkg::dpc_state_type nxt_state;
  // Stored slots are plain flops; no real NV cells here
  logic [7:0]          store_ff [2][4];
  logic [7:0]          wiper_pos_ff [2];
  logic [7:0]          pend_val_ff [2];
  logic                pend_ff [2];
  logic [1:0]          dly_ff;
  logic [NV_CNT_W-1:0] nv_cnt_ff;
  logic                sck_prev_ff;
  logic                cs_prev_ff;
  logic [2:0]          bit_cnt_ff;
  logic [7:0]          sh_ff;
  logic [7:0]          instr_ff;
  logic [7:0]          data_ff;
  logic [7:0]          so_sh_ff;

  // ==========================================================
  // Edge and byte decode
  // Serial pins are oversampled; levels must span two clocks
  wire        cs_fall   = cs_prev_ff & ~i_cs_n;
  wire        cs_rise   = ~cs_prev_ff & i_cs_n;
  wire        sck_rise  = ~i_cs_n & i_sck & ~sck_prev_ff;
  wire        sck_fall  = ~i_cs_n & ~i_sck & sck_prev_ff;
  wire [7:0]  byte_nxt  = {sh_ff[6:0], i_si};
  wire        byte_done = sck_rise & (bit_cnt_ff == dpc_pkg::BIT_LAST);
  wire        busy      = (nv_cnt_ff != '0);
  wire [3:0]  op        = instr_ff[dpc_pkg::OPC_MSB:dpc_pkg::OPC_LSB];
  wire        pot       = instr_ff[dpc_pkg::POT_BIT];
  wire [1:0]  slot      = {instr_ff[dpc_pkg::SEL_HI_BIT],
                           instr_ff[dpc_pkg::SEL_LO_BIT]};
  wire [3:0]  nop       = byte_nxt[dpc_pkg::OPC_MSB:dpc_pkg::OPC_LSB];
  wire        npot      = byte_nxt[dpc_pkg::POT_BIT];
  wire [1:0]  nslot     = {byte_nxt[dpc_pkg::SEL_HI_BIT],
                           byte_nxt[dpc_pkg::SEL_LO_BIT]};
  wire        nstatus   = (byte_nxt == dpc_pkg::STATUS_INSTR);

  wire ident_ok =
    (byte_nxt[dpc_pkg::OPC_MSB:dpc_pkg::OPC_LSB] ==
     dpc_pkg::DEV_TYPE_CODE) &
    ~byte_nxt[dpc_pkg::ADR_PAD_HI] & ~byte_nxt[dpc_pkg::ADR_PAD_LO] &
    (byte_nxt[dpc_pkg::ADR_HI_BIT] == i_addr_pin_hi) &
    (byte_nxt[dpc_pkg::ADR_LO_BIT] == i_addr_pin_lo);

  wire n_three = nstatus | (nop == dpc_pkg::OP_RD_WIPER) |
                 (nop == dpc_pkg::OP_WR_WIPER) |
                 (nop == dpc_pkg::OP_RD_STORE) |
                 (nop == dpc_pkg::OP_WR_STORE);
  wire n_step  = ~nstatus & (nop == dpc_pkg::OP_STEP);

  wire [7:0] rd_val =
    nstatus ? {7'h00, busy} :
    (nop == dpc_pkg::OP_RD_WIPER) ? wiper_pos_ff[npot] :
    store_ff[npot][nslot];

  // execute only on clean frame end
  wire commit = cs_rise & (state_ff == dpc_pkg::ST_ARMED);
  wire is_stat = (instr_ff == dpc_pkg::STATUS_INSTR);
  wire nv_go = commit & ~busy & ~is_stat &
               ((op == dpc_pkg::OP_WR_STORE) |
                (op == dpc_pkg::OP_COPY_W2S) |
                (op == dpc_pkg::OP_GCOPY_W2S));
  wire global_op = (op == dpc_pkg::OP_GCOPY_S2W) |
                   (op == dpc_pkg::OP_GCOPY_W2S);
  wire s2w_go = commit & ~is_stat & ((op == dpc_pkg::OP_COPY_S2W) |
                                     (op == dpc_pkg::OP_GCOPY_S2W));
  wire wr_wiper = commit & ~is_stat & (op == dpc_pkg::OP_WR_WIPER);
  wire dly_done = (dly_ff == 2'h1);
  // steps run until chip select rises
  wire step_go = sck_rise & (state_ff == dpc_pkg::ST_STEP);

  // ==========================================================
  // Frame sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      // every command opens at select fall
      dpc_pkg::ST_IDLE:   if (cs_fall) nxt_state = dpc_pkg::ST_IDENT;
      dpc_pkg::ST_IDENT:  if (byte_done) begin
        nxt_state = ident_ok ? dpc_pkg::ST_INSTR : dpc_pkg::ST_IGNORE;
      end
      // unknown opcode ignored to frame end
      dpc_pkg::ST_INSTR:  if (byte_done) begin
        if (!instr_ok(byte_nxt)) nxt_state = dpc_pkg::ST_IGNORE;
        else if (n_step)         nxt_state = dpc_pkg::ST_STEP;
        else if (n_three)        nxt_state = dpc_pkg::ST_DATA;
        else                     nxt_state = dpc_pkg::ST_ARMED;
      end
      dpc_pkg::ST_DATA:   if (byte_done) nxt_state = dpc_pkg::ST_ARMED;
      // Extra clocks after a full command void it
      dpc_pkg::ST_ARMED:  if (sck_rise) nxt_state = dpc_pkg::ST_IGNORE;
      // Stepping ends only when chip select rises
      dpc_pkg::ST_STEP:   nxt_state = dpc_pkg::ST_STEP;
      dpc_pkg::ST_IGNORE: nxt_state = dpc_pkg::ST_IGNORE;
      default:            nxt_state = dpc_pkg::ST_IDLE;
    endcase
    if (cs_rise) nxt_state = dpc_pkg::ST_IDLE;
    if (cs_fall) nxt_state = dpc_pkg::ST_IDENT;
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_ff    <= dpc_pkg::ST_IDLE;
      sck_prev_ff <= 1'b0;
      cs_prev_ff  <= 1'b1;
      bit_cnt_ff  <= 3'h0;
      sh_ff       <= 8'h00;
    end else begin
      state_ff    <= nxt_state;
      sck_prev_ff <= i_sck;
      cs_prev_ff  <= i_cs_n;
      if (cs_fall) bit_cnt_ff <= 3'h0;
      else if (sck_rise) bit_cnt_ff <= bit_cnt_ff + 3'h1;
      if (sck_rise) sh_ff <= byte_nxt;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      instr_ff <= 8'h00;
      data_ff  <= 8'h00;
      so_sh_ff <= 8'h00;
    end else begin
      if (byte_done && state_ff == dpc_pkg::ST_INSTR) begin
        instr_ff <= byte_nxt;
        so_sh_ff <= rd_val;
      end else if (sck_fall && state_ff == dpc_pkg::ST_DATA &&
                   bit_cnt_ff != 3'h0) begin
        // First fall after the instruction keeps the MSB up
        so_sh_ff <= {so_sh_ff[6:0], 1'b0};
      end
      if (byte_done && state_ff == dpc_pkg::ST_DATA) data_ff <= byte_nxt;
    end
  end

  wire rd_op = is_stat | (op == dpc_pkg::OP_RD_WIPER) |
               (op == dpc_pkg::OP_RD_STORE);
  assign o_so    = so_sh_ff[7];
  assign o_so_oe = (state_ff == dpc_pkg::ST_DATA) & rd_op;

  // ==========================================================
  // NV write timer and wiper copy delay
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      nv_cnt_ff <= '0;
      dly_ff    <= 2'h0;
    end else begin
      // busy for the whole bounded write
      // Width covers the full default write time
      if (nv_go) nv_cnt_ff <= NV_CNT_W'(NV_WRITE_CYC);
      else if (busy) nv_cnt_ff <= nv_cnt_ff - NV_CNT_W'(1);
      // copied value lands after a delay
      if (s2w_go) dly_ff <= dpc_pkg::WIPER_DLY_CYC;
      else if (dly_ff != 2'h0) dly_ff <= dly_ff - 2'h1;
    end
  end

  assign o_write_busy_flag = busy;
  assign o_wiper0 = wiper_pos_ff[0];
  assign o_wiper1 = wiper_pos_ff[1];

  // ==========================================================
  // Per-pot registers
  for (genvar p = 0; p < 2; p++) begin : g_pot
    // pot select picks the register pair; global copies take both pairs
    wire mine    = global_op | (pot == 1'(p));
    wire wr_en   = wr_wiper & (pot == 1'(p));
    wire cp_en   = s2w_go & mine;
    wire st_en   = step_go & (pot == 1'(p));
    wire nv_en   = nv_go & mine;
    wire at_max  = (wiper_pos_ff[p] == dpc_pkg::WIPER_MAX);
    wire at_min  = (wiper_pos_ff[p] == dpc_pkg::WIPER_MIN);
    wire [7:0] step_val =
      i_si ? (at_max ? wiper_pos_ff[p] : wiper_pos_ff[p] + 8'h01) :
             (at_min ? wiper_pos_ff[p] : wiper_pos_ff[p] - 8'h01);
    wire [7:0] store_val =
      (op == dpc_pkg::OP_WR_STORE) ? data_ff : wiper_pos_ff[p];

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
        wiper_pos_ff[p] <= dpc_pkg::STORE_RST;
        pend_ff[p]      <= 1'b0;
        pend_val_ff[p]  <= 8'h00;
      end else begin
        if (cp_en) begin
          pend_ff[p]     <= 1'b1;
          pend_val_ff[p] <= store_ff[p][slot];
        end else if (dly_done) begin
          pend_ff[p] <= 1'b0;
        end
        // host data straight to wiper
        // Direct write wins over a copy landing in the same cycle; a copy landing later overwrites it
        if (wr_en) wiper_pos_ff[p] <= data_ff;
        else if (dly_done && pend_ff[p]) wiper_pos_ff[p] <= pend_val_ff[p];
        else if (st_en) wiper_pos_ff[p] <= step_val;
      end
    end

    for (genvar s = 0; s < 4; s++) begin : g_slot
      always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
          store_ff[p][s] <= dpc_pkg::STORE_RST;
        end else if (nv_en && slot == 2'(s)) begin
          store_ff[p][s] <= store_val;
        end
      end
    end
  end

endmodule

/* File: test/dpc_host_model.sv */
`timescale 1ns/1ps
module dpc_host_model (
  // Clock
  input  wire logic i_clk_sys,
  // Serial link
  input  wire logic i_so,
  output      logic o_sck,
  output      logic o_cs_n,
  output      logic o_si
);
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
  end
  // ========
  // frame opens low
  task automatic open_frame();
    @(posedge i_clk_sys);
    o_cs_n <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
  endtask
  task automatic close_frame();
    repeat (2) @(posedge i_clk_sys);
    o_cs_n <= 1'b1;
    // Released line must not keep its last value
    o_si <= ~o_si;
    repeat (4) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      o_si <= tx[i];
      repeat (2) @(posedge i_clk_sys);
      @(negedge i_clk_sys);
      rx[i] = i_so;
      @(posedge i_clk_sys);
      o_sck <= 1'b1;
      repeat (2) @(posedge i_clk_sys);
      o_sck <= 1'b0;
    end
  endtask
endmodule

/* File: test/dpc_decoder_properties.sv */
`timescale 1ns/1ps
module dpc_decoder_properties #(
  parameter int NV_WRITE_CYC = 20
) (
  // Clock and reset
  input wire logic       i_clk_sys,
  input wire logic       i_arst_n,
  // Serial link
  input wire logic       i_sck,
  input wire logic       i_cs_n,
  input wire logic       i_si,
  input wire logic       o_so,
  input wire logic       o_so_oe,
  input wire logic       i_addr_pin_hi,
  input wire logic       i_addr_pin_lo,
  // Pot state
  input wire logic [7:0] o_wiper0,
  input wire logic [7:0] o_wiper1,
  input wire logic       o_write_busy_flag
);
  int busy_cnt_ff;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) busy_cnt_ff <= 0;
    else busy_cnt_ff <= o_write_busy_flag ? busy_cnt_ff + 1 : 0;
  end
  // ========
  chk_oe_idle:
    assert property (i_cs_n [*3] |-> !o_so_oe) else $error("so driven");
  chk_oe_rise:
    assert property ($rose(o_so_oe) |-> $past(i_sck) && !$past(i_sck, 2))
    else $error("so enable off sck rise");
  chk_busy_start:
    assert property ($rose(o_write_busy_flag) |-> $past(i_cs_n))
    else $error("busy set inside frame");
  chk_wiper_quiet:
    assert property (!$stable(o_wiper0) || !$stable(o_wiper1)
      |-> $past(i_cs_n) || $past(i_sck)) else $error("wiper moved");
  chk_step_unit:
    assert property (!i_cs_n && !$past(i_cs_n) && !$past(i_cs_n, 2)
      && !$stable(o_wiper0) |-> o_wiper0 == ($past(i_si) ?
      $past(o_wiper0) + 8'h01 : $past(o_wiper0) - 8'h01))
    else $error("step not one");
  chk_sat_top:
    assert property (!i_cs_n && !$past(i_cs_n) && !$past(i_cs_n, 2)
      && $past(i_sck) && !$past(i_sck, 2) && $past(i_si)
      && $past(o_wiper0) == 8'hff |-> o_wiper0 == 8'hff)
    else $error("wiper wrapped");
  chk_busy_len:
    assert property ($fell(o_write_busy_flag)
      |-> busy_cnt_ff >= NV_WRITE_CYC - 1) else $error("busy short");
  chk_busy_max:
    assert property (busy_cnt_ff <= NV_WRITE_CYC + 1)
    else $error("busy long");
endmodule
bind dpc_decoder dpc_decoder_properties
  #(.NV_WRITE_CYC(NV_WRITE_CYC)) u_chk (
  .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_sck(i_sck),
  .i_cs_n(i_cs_n), .i_si(i_si), .o_so(o_so), .o_so_oe(o_so_oe),
  .i_addr_pin_hi(i_addr_pin_hi), .i_addr_pin_lo(i_addr_pin_lo),
  .o_wiper0(o_wiper0), .o_wiper1(o_wiper1),
  .o_write_busy_flag(o_write_busy_flag));

/* File: test/testbench.sv */
`timescale 1ns/1ps
module testbench;
  localparam int NV_CYC = 400;
  logic       clk, arst_n, sck, cs_n, si, so, oe, a_hi, a_lo, busy;
  logic [7:0] w0, w1, rx;
  int         error_cnt, tests_run, cyc;

  dpc_decoder #(.NV_WRITE_CYC(NV_CYC)) dut (.i_clk_sys(clk),
    .i_arst_n(arst_n), .i_sck(sck), .i_cs_n(cs_n), .i_si(si), .o_so(so),
    .o_so_oe(oe), .i_addr_pin_hi(a_hi), .i_addr_pin_lo(a_lo),
    .o_wiper0(w0), .o_wiper1(w1), .o_write_busy_flag(busy));
  dpc_host_model host (.i_clk_sys(clk), .i_so(so), .o_sck(sck),
    .o_cs_n(cs_n), .o_si(si));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("[FAIL] %0t timeout", $time);
      finish_test();
    end
  end
  // ========
  function automatic logic [7:0] ins(input logic [3:0] op,
    input logic [1:0] sel, input logic pot);
    return {op, sel, 1'b0, pot};
  endfunction
  task automatic chk(input logic [7:0] got, exp, input string what);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic frame(input logic [7:0] ident, op_b, dat, input int n);
    host.open_frame();
    host.xfer(ident, rx);
    if (n > 1) host.xfer(op_b, rx);
    if (n > 2) host.xfer(dat, rx);
    host.close_frame();
  endtask
  task automatic cmd(input logic [7:0] op_b, dat, input int n);
    frame({dpc_pkg::DEV_TYPE_CODE, 2'b00, a_hi, a_lo}, op_b, dat, n);
  endtask
  task automatic wait_idle();
    for (int k = 0; k < NV_CYC + 20 && busy !== 1'b0; k++)
      @(posedge clk);
    chk({7'h00, busy}, 8'h00, "busy stuck");
  endtask
  // ========
  task automatic t_wiper();
    cmd(ins(dpc_pkg::OP_WR_WIPER, 2'h0, 1'b0), 8'h5a, 3);
    cmd(ins(dpc_pkg::OP_WR_WIPER, 2'h0, 1'b1), 8'hc3, 3);
    chk(w0, 8'h5a, "wiper0 write");
    chk(w1, 8'hc3, "wiper1 write");
    cmd(ins(dpc_pkg::OP_RD_WIPER, 2'h0, 1'b1), 8'h00, 3);
    chk(rx, 8'hc3, "wiper1 read");
    $display("wiper test done");
  endtask
  task automatic t_store();
    cmd(ins(dpc_pkg::OP_WR_STORE, 2'h2, 1'b1), 8'h3c, 3);
    chk({7'h00, busy}, 8'h01, "busy set");
    cmd(dpc_pkg::STATUS_INSTR, 8'h00, 3);
    chk(rx, 8'h01, "status busy");
    cmd(ins(dpc_pkg::OP_WR_STORE, 2'h2, 1'b1), 8'h77, 3);
    wait_idle();
    cmd(dpc_pkg::STATUS_INSTR, 8'h00, 3);
    chk(rx, 8'h00, "status idle");
    cmd(ins(dpc_pkg::OP_RD_STORE, 2'h2, 1'b1), 8'h00, 3);
    chk(rx, 8'h3c, "slot read");
    cmd(ins(dpc_pkg::OP_RD_STORE, 2'h2, 1'b0), 8'h00, 3);
    chk(rx, 8'h00, "other pot slot");
    $display("store test done");
  endtask
  task automatic t_copy();
    cmd(ins(dpc_pkg::OP_COPY_S2W, 2'h2, 1'b1), 8'h00, 2);
    chk(w1, 8'h3c, "slot to wiper");
    cmd(ins(dpc_pkg::OP_COPY_W2S, 2'h1, 1'b0), 8'h00, 2);
    chk({7'h00, busy}, 8'h01, "copy busy");
    wait_idle();
    cmd(ins(dpc_pkg::OP_RD_STORE, 2'h1, 1'b0), 8'h00, 3);
    chk(rx, 8'h5a, "wiper to slot");
    cmd(ins(dpc_pkg::OP_GCOPY_W2S, 2'h3, 1'b0), 8'h00, 2);
    wait_idle();
    cmd(ins(dpc_pkg::OP_WR_WIPER, 2'h0, 1'b0), 8'h00, 3);
    cmd(ins(dpc_pkg::OP_WR_WIPER, 2'h0, 1'b1), 8'h00, 3);
    cmd(ins(dpc_pkg::OP_GCOPY_S2W, 2'h3, 1'b0), 8'h00, 2);
    chk(w0, 8'h5a, "global pot0");
    chk(w1, 8'h3c, "global pot1");
    $display("copy test done");
  endtask
  task automatic t_step();
    cmd(ins(dpc_pkg::OP_WR_WIPER, 2'h0, 1'b0), 8'hfc, 3);
    cmd(ins(dpc_pkg::OP_STEP, 2'h0, 1'b0), 8'hff, 3);
    chk(w0, 8'hff, "step up top");
    cmd(ins(dpc_pkg::OP_STEP, 2'h0, 1'b0), 8'h00, 3);
    chk(w0, 8'hf7, "step down");
    cmd(ins(dpc_pkg::OP_STEP, 2'h0, 1'b1), 8'h01, 3);
    chk(w1, 8'h36, "mixed steps");
    cmd(ins(dpc_pkg::OP_WR_WIPER, 2'h0, 1'b0), 8'h03, 3);
    cmd(ins(dpc_pkg::OP_STEP, 2'h0, 1'b0), 8'h00, 3);
    chk(w0, 8'h00, "step down floor");
    $display("step test done");
  endtask
  task automatic t_refuse();
    frame({dpc_pkg::DEV_TYPE_CODE, 2'b00, ~a_hi, a_lo},
      ins(dpc_pkg::OP_WR_WIPER, 2'h0, 1'b0), 8'h99, 3);
    frame({~dpc_pkg::DEV_TYPE_CODE, 2'b00, a_hi, a_lo},
      ins(dpc_pkg::OP_WR_WIPER, 2'h0, 1'b0), 8'h99, 3);
    chk(w0, 8'h00, "foreign id");
    cmd(ins(4'h3, 2'h0, 1'b0), 8'h99, 3);
    cmd(ins(dpc_pkg::OP_WR_WIPER, 2'h0, 1'b0), 8'h99, 2);
    cmd(ins(dpc_pkg::OP_WR_STORE, 2'h0, 1'b0), 8'h99, 2);
    chk(w0, 8'h00, "bad or short");
    chk({7'h00, busy}, 8'h00, "short store");
    @(posedge clk);
    a_hi <= 1'b0;
    a_lo <= 1'b1;
    // Let the new straps settle before the byte is built from them
    @(posedge clk);
    cmd(ins(dpc_pkg::OP_WR_WIPER, 2'h0, 1'b0), 8'h21, 3);
    chk(w0, 8'h21, "new address");
    $display("refuse test done");
  endtask
  task automatic finish_test();
    $display("Checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    arst_n = 1'b0;
    a_hi = 1'b1;
    a_lo = 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_wiper();
    t_store();
    t_copy();
    t_step();
    t_refuse();
    finish_test();
  end
endmodule
